// File: logic/rvq_consts.svh
// register offsets, field positions, reset values and timing counts of the ring qualifier
`ifndef RVQ_CONSTS_SVH
`define RVQ_CONSTS_SVH

// register offsets
`define RVQ_OFS_CTL1 8'h46
`define RVQ_OFS_CTL2 8'h47
`define RVQ_OFS_CTL3 8'h48
`define RVQ_OFS_STAT 8'h4c
`define RVQ_OFS_MASK 8'h4d
`define RVQ_OFS_STATE 8'h4e

// reset values
`define RVQ_RST_CTL1 8'h96
`define RVQ_RST_CTL2 8'h2d
`define RVQ_RST_CTL3 8'h19
`define RVQ_RST_MASK 3'h0

// control three keeps bit 6 at zero
`define RVQ_CTL3_WMASK 8'hbf

// status bit positions
`define RVQ_ST_VALID 0
`define RVQ_ST_BAD 1
`define RVQ_ST_END 2

// timing figures
`define RVQ_CLK_NS 4
`define RVQ_TICK_MS 2
`define RVQ_TICK_CYC (`RVQ_TICK_MS * 1000000 / `RVQ_CLK_NS)
`define RVQ_DLY_STEP_MS 256
`define RVQ_TO_STEP_MS 128
`define RVQ_DLY_STEP_TK (`RVQ_DLY_STEP_MS / `RVQ_TICK_MS)
`define RVQ_TO_STEP_TK (`RVQ_TO_STEP_MS / `RVQ_TICK_MS)

// confirmation windows in ms, codes 0 to 7
`define RVQ_WIN0_MS 100
`define RVQ_WIN1_MS 150
`define RVQ_WIN2_MS 200
`define RVQ_WIN3_MS 256
`define RVQ_WIN4_MS 384
`define RVQ_WIN5_MS 512
`define RVQ_WIN6_MS 640
`define RVQ_WIN7_MS 1024

`endif

// File: logic/rvq_pkg.sv
// types shared by the ring qualifier
package rvq_pkg;

    // qualification states
    typedef enum logic [1:0] {
        RVQ_IDLE = 2'b00,
        RVQ_QUAL = 2'b01,
        RVQ_DELAY = 2'b10,
        RVQ_VALID = 2'b11
    } rvq_state_e;

    // counts of 2 ms ticks
    typedef logic [9:0] rvq_tick_t;

endpackage

// File: logic/rvq_top.sv
// ring validation qualifier: interval checks, confirmation, delay, timeout
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "rvq_consts.svh"
// one clock domain; the asynchronous inputs are the reset and the line polarity,
// and only the polarity is synchronised before any logic reads it

module rvq_top
    import rvq_pkg::*;
#(
    parameter int TICK_CYCLES = `RVQ_TICK_CYC
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [7:0] regRdData,
    // line-side polarity from ring detector
    input wire logic ringPolarity,
    // results
    output logic ringValid,
    output logic ringIrq
);

    // tick counter width follows the parameter, so a short sim tick
    // and the full 2 ms count share one description
    localparam int TW = $clog2(TICK_CYCLES + 1);

    // window codes are not linear, hence a table rather than a product;
    // every code is legal, so the case needs no default
    // window length in ticks for a confirm code
    function automatic rvq_tick_t winTicks(input logic [2:0] code);
        unique case (code)
            3'h0: winTicks = 10'(`RVQ_WIN0_MS / `RVQ_TICK_MS);
            3'h1: winTicks = 10'(`RVQ_WIN1_MS / `RVQ_TICK_MS);
            3'h2: winTicks = 10'(`RVQ_WIN2_MS / `RVQ_TICK_MS);
            3'h3: winTicks = 10'(`RVQ_WIN3_MS / `RVQ_TICK_MS);
            3'h4: winTicks = 10'(`RVQ_WIN4_MS / `RVQ_TICK_MS);
            3'h5: winTicks = 10'(`RVQ_WIN5_MS / `RVQ_TICK_MS);
            3'h6: winTicks = 10'(`RVQ_WIN6_MS / `RVQ_TICK_MS);
            3'h7: winTicks = 10'(`RVQ_WIN7_MS / `RVQ_TICK_MS);
        endcase
    endfunction

    // field layout: control one holds delay low bits and the fast limit,
    // control two the delay top bit, timeout and window, control three
    // the enable and the assertion time
    // control registers
    logic [7:0] ctl1_r; // delay low bits, max-frequency threshold
    logic [7:0] ctl2_r; // delay bit 2, timeout, confirm code
    logic [7:0] ctl3_r; // enable, assertion time
    logic [2:0] stat_r; // sticky events
    logic [2:0] mask_r; // interrupt mask
    logic [2:0] statNxt; // status after set and clear

    // the pin is asynchronous to sys_clk; two stages keep a metastable
    // level away from the change detector, at two cycles of latency
    // line event sync
    logic polSync1_r; // first stage, read only by second
    logic polSync2_r; // second stage
    logic polLast_r; // previous settled level
    logic ringEvt; // one-cycle polarity change

    // one shared tick drives every counter below, so all intervals are
    // measured in whole ticks with up to one tick of phase error
    // timebase
    logic [TW-1:0] tickCnt_r;
    logic tick_r; // one pulse per 2 ms

    // event flags are one-cycle pulses into the sticky status; they are
    // registered so status and interrupt see settled values
    // qualification state
    rvq_state_e state_r;
    logic [5:0] ivTimer_r; // interval timer
    logic ivExp_r; // interval timer ran out
    rvq_tick_t confCnt_r; // ticks into confirm window
    rvq_tick_t quietCnt_r; // ticks since last event
    rvq_tick_t dlyCnt_r; // ticks into indicate delay
    logic evValid_r; // ring now indicated
    logic evBad_r; // interval failed
    logic evEnd_r; // ringing finished

    // plain wires decoded from the control registers; software may change
    // them at any time and the sequence picks up the new value at once
    // decoded fields
    logic qualEn;
    logic [5:0] rasVal;
    logic [5:0] rmxVal;
    logic [2:0] dlyCode;
    logic [3:0] rtoCode;
    logic [3:0] rtoEff;
    rvq_tick_t dlyTicks;
    rvq_tick_t toTicks;
    rvq_tick_t confTicks;
    logic wrCtl;

    // field extraction; the delay code spans two control registers
    assign qualEn = ctl3_r[7];
    assign rasVal = ctl3_r[5:0];
    assign rmxVal = ctl1_r[5:0];
    assign dlyCode = {ctl2_r[7], ctl1_r[7:6]};
    assign rtoCode = ctl2_r[6:3];
    // code zero is invalid; treat it as one step rather than never ending
    assign rtoEff = (rtoCode == 4'h0) ? 4'h1 : rtoCode;
    // linear delay, zero code gives none
    assign dlyTicks = 10'(dlyCode * `RVQ_DLY_STEP_TK);
    assign toTicks = 10'(rtoEff * `RVQ_TO_STEP_TK);
    assign confTicks = winTicks(ctl2_r[2:0]);
    // one-cycle pulse on either edge of the settled polarity
    assign ringEvt = polSync2_r ^ polLast_r;
    // every write strobe goes to the control decode; status decodes its own
    assign wrCtl = regWrStb;

    // both polarity edges count as events; the reset level is low, so a line
    // idling low gives no false event after reset
    // pin sync, then change detect on the settled copy
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            polSync1_r <= 1'b0;
            polSync2_r <= 1'b0;
            polLast_r <= 1'b0;
        end else begin
            polSync1_r <= ringPolarity;
            polSync2_r <= polSync1_r;
            polLast_r <= polSync2_r;
        end
    end

    // trade-off: a free tick lets the first interval after an event be up
    // to one tick short, which the threshold margin is meant to absorb
    // 2 ms timebase; free running so ticks stay evenly spaced
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tickCnt_r <= '0;
            tick_r <= 1'b0;
        end else if (tickCnt_r == TW'(TICK_CYCLES - 1)) begin
            // last count of the period: wrap and pulse
            tickCnt_r <= '0;
            tick_r <= 1'b1;
        end else begin
            tickCnt_r <= tickCnt_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

    // writes land on the strobe edge; the slave never stalls the master.
    // status is written elsewhere because its clear must lose to new events
    // control register writes
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctl1_r <= `RVQ_RST_CTL1;
            ctl2_r <= `RVQ_RST_CTL2;
            ctl3_r <= `RVQ_RST_CTL3;
            mask_r <= `RVQ_RST_MASK;
        end else if (wrCtl) begin
            unique case (regAddr)
                `RVQ_OFS_CTL1: ctl1_r <= regWrData;
                `RVQ_OFS_CTL2: ctl2_r <= regWrData;
                // reserved bit kept at zero
                `RVQ_OFS_CTL3: ctl3_r <= regWrData & `RVQ_CTL3_WMASK;
                `RVQ_OFS_MASK: mask_r <= regWrData[2:0];
                // other addresses ignored
                default: ;
            endcase
        end
    end

    // the timer stops at zero and raises the expiry flag; a load on the same
    // edge as a tick wins, so that tick is not counted against the interval
    // interval timer, loaded on every event
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ivTimer_r <= 6'h00;
            ivExp_r <= 1'b0;
        end else if (!qualEn) begin
            // disabled: timer cleared so a later enable starts clean
            ivTimer_r <= 6'h00;
            ivExp_r <= 1'b0;
        end else if (ringEvt) begin
            ivTimer_r <= rasVal;
            // zero assertion time means already expired
            ivExp_r <= (rasVal == 6'h00);
        end else if (tick_r && ivTimer_r != 6'h00) begin
            ivTimer_r <= ivTimer_r - 6'h01;
            ivExp_r <= (ivTimer_r == 6'h01);
        end
    end

    // counts whole ticks since the last crossing and saturates at the
    // timeout so it cannot wrap and hide a finished ring
    // silence counter for end of ringing
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            quietCnt_r <= '0;
        end else if (!qualEn || ringEvt || state_r == RVQ_IDLE) begin
            quietCnt_r <= '0;
        end else if (tick_r && quietCnt_r < toTicks) begin
            quietCnt_r <= quietCnt_r + 10'h001;
        end
    end

    // idle waits for a first event, qualifying checks every interval over
    // the window, delay holds off the indication, valid holds it; the
    // enable overrides every state and the timeout every state but idle
    // qualification sequence
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= RVQ_IDLE;
            confCnt_r <= '0;
            dlyCnt_r <= '0;
            ringValid <= 1'b0;
            evValid_r <= 1'b0;
            evBad_r <= 1'b0;
            evEnd_r <= 1'b0;
        end else begin
            evValid_r <= 1'b0;
            evBad_r <= 1'b0;
            evEnd_r <= 1'b0;
            if (!qualEn) begin
                // disabled: drop everything
                state_r <= RVQ_IDLE;
                confCnt_r <= '0;
                dlyCnt_r <= '0;
                ringValid <= 1'b0;
            end else if (state_r != RVQ_IDLE && quietCnt_r >= toTicks) begin
                // silent too long: ringing over
                state_r <= RVQ_IDLE;
                ringValid <= 1'b0;
                evEnd_r <= 1'b1;
            end else begin
                unique case (state_r)
                    RVQ_IDLE: begin
                        // first event opens a window
                        // the timer is loaded by its own process on this edge
                        if (ringEvt) begin
                            state_r <= RVQ_QUAL;
                            confCnt_r <= '0;
                        end
                    end
                    RVQ_QUAL: begin
                        if (ringEvt && (ivExp_r || ivTimer_r > rmxVal)) begin
                            // too slow or too fast
                            evBad_r <= 1'b1;
                            confCnt_r <= '0;
                        end else if (tick_r) begin
                            // an open expiry blocks the verdict
                            if (confCnt_r >= confTicks - 10'h001 && !ivExp_r) begin
                                confCnt_r <= '0;
                                dlyCnt_r <= '0;
                                if (dlyTicks == '0) begin
                                    state_r <= RVQ_VALID;
                                    ringValid <= 1'b1;
                                    evValid_r <= 1'b1;
                                end else begin
                                    state_r <= RVQ_DELAY;
                                end
                            end else if (confCnt_r < confTicks) begin
                                confCnt_r <= confCnt_r + 10'h001;
                            end
                        end
                    end
                    RVQ_DELAY: begin
                        // hold off the indication
                        // intervals are not checked here; only the timeout or a disable cuts it short
                        if (tick_r) begin
                            if (dlyCnt_r >= dlyTicks - 10'h001) begin
                                state_r <= RVQ_VALID;
                                ringValid <= 1'b1;
                                evValid_r <= 1'b1;
                            end else begin
                                dlyCnt_r <= dlyCnt_r + 10'h001;
                            end
                        end
                    end
                    RVQ_VALID: begin
                        // stays until timeout or disable
                        // later intervals are not rechecked once valid
                        ringValid <= 1'b1;
                    end
                endcase
            end
        end
    end

    // a clear and a new event on the same edge leave the bit set, so
    // software never loses an event it has not yet seen
    // sticky status: new events win over a write-one clear
    always_comb begin
        statNxt = stat_r;
        if (regWrStb && regAddr == `RVQ_OFS_STAT) begin
            statNxt = stat_r & ~regWrData[2:0];
        end
        statNxt[`RVQ_ST_VALID] = statNxt[`RVQ_ST_VALID] | evValid_r;
        statNxt[`RVQ_ST_BAD] = statNxt[`RVQ_ST_BAD] | evBad_r;
        statNxt[`RVQ_ST_END] = statNxt[`RVQ_ST_END] | evEnd_r;
    end

    // the interrupt follows the next status value: it rises with the status
    // bit and drops with its clear, one edge after a mask write
    // status and interrupt line
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stat_r <= 3'h0;
            ringIrq <= 1'b0;
        end else begin
            stat_r <= statNxt;
            ringIrq <= |(statNxt & mask_r);
        end
    end

    // idle cycles return zero so a stale value is never mistaken for a read;
    // the state view lets software watch qualification progress
    // read data valid the cycle after the strobe only
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            regRdData <= 8'h00;
        end else if (!regRdStb) begin
            regRdData <= 8'h00;
        end else begin
            unique case (regAddr)
                `RVQ_OFS_CTL1: regRdData <= ctl1_r;
                `RVQ_OFS_CTL2: regRdData <= ctl2_r;
                `RVQ_OFS_CTL3: regRdData <= ctl3_r;
                `RVQ_OFS_STAT: regRdData <= {5'h00, stat_r};
                `RVQ_OFS_MASK: regRdData <= {5'h00, mask_r};
                `RVQ_OFS_STATE: regRdData <= {ringValid, ivExp_r, 4'h0, state_r};
                // unmapped reads as zero
                default: regRdData <= 8'h00;
            endcase
        end
    end

endmodule

// File: dv/rvq_asserts.sv
// port checker for the ring qualifier
`timescale 1ns/1ps
module rvq_asserts #(
    parameter int TICK_CYCLES = 4
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire logic [7:0] regRdData,
    // line and results
    input wire logic ringPolarity,
    input wire logic ringValid,
    input wire logic ringIrq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    logic enR; // shadow of the enable bit
    logic [2:0] maskR; // shadow of the mask
    logic polR; // polarity one cycle ago
    int quietR; // cycles since the last crossing
    int enCntR; // cycles spent enabled
    // shadows are kept from the port so no internal view is needed
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            enR <= 1'b0;
            maskR <= 3'h0;
        end else if (regWrStb && regAddr == 8'h48) begin
            enR <= regWrData[7];
        end else if (regWrStb && regAddr == 8'h4d) begin
            maskR <= regWrData[2:0];
        end
    end
    // counters; slack in the checks covers sync delay and tick phase
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            polR <= 1'b0;
            quietR <= 0;
            enCntR <= 0;
        end else begin
            polR <= ringPolarity;
            quietR <= (ringPolarity != polR) ? 0 : quietR + 1;
            enCntR <= enR ? enCntR + 1 : 0;
        end
    end
    rd_idle_a: assert property (!regRdStb |=> regRdData == 8'h00)
        else $error("read data not zero outside a read");
    rd_unmapped_a: assert property (regRdStb && (regAddr < 8'h46 || regAddr > 8'h4e) |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    rsvd_bit_a: assert property (regRdStb && regAddr == 8'h48 |=> !regRdData[6])
        else $error("reserved enable-register bit read as one");
    mask_echo_a: assert property (regRdStb && regAddr == 8'h4d |=> regRdData[2:0] == maskR)
        else $error("mask readback differs");
    valid_rise_a: assert property ($rose(ringValid) |-> enR && enCntR + TICK_CYCLES >= 50 * TICK_CYCLES)
        else $error("valid ring before a full window");
    valid_fall_a: assert property ($fell(ringValid) |-> !enR || quietR + TICK_CYCLES + 8 >= 64 * TICK_CYCLES)
        else $error("valid ring dropped before timeout");
    off_drop_a: assert property (regWrStb && regAddr == 8'h48 && !regWrData[7] |-> ##[1:3] !ringValid)
        else $error("valid ring kept after disable");
    irq_mask_a: assert property (regWrStb && regAddr == 8'h4d && regWrData[2:0] == 3'h0 |-> ##[1:3] !ringIrq)
        else $error("interrupt kept with all masked");
    irq_valid_a: assert property ($rose(ringValid) && maskR[0] |-> ##[0:2] ringIrq)
        else $error("no interrupt on valid ring");
    // main scenarios reached
    cover property ($rose(ringValid));
    cover property ($fell(ringValid));
    cover property ($rose(ringIrq));
endmodule

// File: dv/rvq_ring_src.sv
// ring detector model: one polarity crossing per gap while running
`timescale 1ns/1ps
module rvq_ring_src (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // spacing in clocks and run control
    input wire logic [15:0] gap,
    input wire logic run,
    // polarity towards the qualifier
    output logic ringPolarity
);
    logic [15:0] cntR; // clocks since last crossing
    // line holds its level between bursts; each toggle is one event
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cntR <= 16'h0;
            ringPolarity <= 1'b0;
        end else if (!run) begin
            cntR <= 16'h0;
        end else if (cntR >= gap - 16'h1) begin
            cntR <= 16'h0;
            ringPolarity <= ~ringPolarity;
        end else begin
            cntR <= cntR + 16'h1;
        end
    end
endmodule

// File: dv/ring_validation_qualifier_test.sv
// self-checking bench for the ring qualifier
`timescale 1ns/1ps
module ring_validation_qualifier_test;
    import rvq_pkg::*;
    localparam int T = 4; // clocks per tick, short for sim
    logic sys_clk, rstn, regWrStb, regRdStb, ringValid, ringIrq, ringPolarity, run;
    logic [7:0] regAddr, regWrData, regRdData;
    logic [15:0] gap; // crossing spacing in clocks
    int nMismatch, checkCount, n;
    rvq_top #(.TICK_CYCLES(T)) u_rvq_top(.sys_clk, .rstn, .regAddr, .regWrData, .regWrStb, .regRdStb,
        .regRdData, .ringPolarity, .ringValid, .ringIrq);
    rvq_ring_src u_rvq_ring_src(.sys_clk, .rstn, .gap, .run, .ringPolarity);
    // free-running 250 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // verdict and end of run
    task automatic conclude();
        if (nMismatch == 0 && checkCount > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        checkCount++;
        if (got !== exp) begin
            nMismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge sys_clk);
        regWrStb <= 1'b0;
    endtask
    // read strobe; data stands only in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
        @(posedge sys_clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge sys_clk);
        regRdStb <= 1'b0;
        #1;
        check("regRdData", exp, regRdData & m);
    endtask
    // bounded wait for a ringValid level
    task automatic waitValid(input logic lvl, input int lim);
        for (n = 0; ringValid !== lvl && n < lim; n++) @(posedge sys_clk);
        if (n >= lim) begin
            nMismatch++;
            $display("mismatch ringValid expected %b seen %b", lvl, ringValid);
            conclude();
        end
    endtask
    // ringValid must stay low for c cycles
    task automatic quiet(input int c);
        logic seen;
        seen = 1'b0;
        repeat (c) begin
            @(posedge sys_clk);
            seen = seen | ringValid;
        end
        check("ringValid", 8'h00, {7'h0, seen});
    endtask
    // bounded wait until the line polarity toggles; returns on the edge after it
    task automatic waitCross();
        logic p0;
        p0 = ringPolarity;
        for (n = 0; n < 100 && ringPolarity === p0; n++) @(posedge sys_clk);
        if (n >= 100) begin
            nMismatch++;
            $display("mismatch ringPolarity expected toggle seen %b", ringPolarity);
            conclude();
        end
    endtask
    initial begin
        rstn = 1'b0;
        regAddr = 8'h0;
        regWrData = 8'h0;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
        gap = 16'd60;
        run = 1'b0;
        nMismatch = 0;
        checkCount = 0;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        // reset values and unmapped space
        rd(8'h46, 8'hff, 8'h96);
        rd(8'h47, 8'hff, 8'h2d);
        rd(8'h48, 8'hff, 8'h19);
        rd(8'h4d, 8'hff, 8'h00);
        rd(8'h50, 8'hff, 8'h00);
        // delay 256 ms, threshold 10, timeout 128 ms, window 100 ms, assertion 20
        wr(8'h46, 8'h4a);
        wr(8'h47, 8'h08);
        wr(8'h4d, 8'h07);
        wr(8'h48, 8'hff);
        rd(8'h48, 8'hff, 8'hbf);
        wr(8'h48, 8'h94);
        rd(8'h46, 8'hff, 8'h4a);
        rd(8'h4d, 8'hff, 8'h07);
        // 15-tick spacing lies inside the bounds: window then delay
        run <= 1'b1;
        waitValid(1'b1, 2000);
        check("onset", 8'h01, {7'h0, n >= 768 && n <= 800});
        rd(8'h4c, 8'h01, 8'h01);
        rd(8'h4e, 8'h83, 8'h83);
        wr(8'h4c, 8'h01);
        rd(8'h4c, 8'h01, 8'h00);
        check("ringIrq", 8'h00, {7'h0, ringIrq});
        // stop just after a crossing: ringing ends after 64 ticks
        waitCross();
        run <= 1'b0;
        waitValid(1'b0, 400);
        check("timeout", 8'h01, {7'h0, n >= 250 && n <= 275});
        rd(8'h4c, 8'h04, 8'h04);
        // too fast, then good spacing from a known crossing restarts the window
        wr(8'h4c, 8'h07);
        gap <= 16'd20;
        run <= 1'b1;
        quiet(300);
        rd(8'h4c, 8'h02, 8'h02);
        waitCross();
        gap <= 16'd60;
        // that last fast crossing fails; 50 window and 128 delay ticks follow it
        waitValid(1'b1, 1200);
        check("restart", 8'h01, {7'h0, n >= 708 && n <= 720});
        // disable drops the ring and ignores events
        wr(8'h48, 8'h14);
        waitValid(1'b0, 4);
        wr(8'h4c, 8'h07);
        quiet(200);
        rd(8'h4c, 8'h07, 8'h00);
        // too slow: timer expires before the next crossing
        gap <= 16'd120;
        wr(8'h48, 8'h94);
        quiet(600);
        rd(8'h4c, 8'h02, 8'h02);
        check("ringIrq", 8'h01, {7'h0, ringIrq});
        wr(8'h4d, 8'h00);
        // the mask reaches the interrupt one edge after the write edge
        repeat (2) @(posedge sys_clk);
        check("ringIrq", 8'h00, {7'h0, ringIrq});
        run <= 1'b0;
        conclude();
    end
endmodule
bind rvq_top rvq_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_rvq_asserts(.sys_clk, .rstn, .regAddr, .regWrData,
    .regWrStb, .regRdStb, .regRdData, .ringPolarity, .ringValid, .ringIrq);
